// [verilog/chan_ctl_pkg.sv]
package chan_ctl_pkg;

  // ----------------------------------------------------------------------
  // Stream and frame geometry
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_STREAMS    = 16;
  localparam int unsigned NUM_CHANNELS   = 256;
  localparam int unsigned NUM_CTL_LINES  = 2;
  localparam int unsigned FRAME_PERIODS  = 2048;
  localparam int unsigned CNT_W          = 11;
  localparam logic [10:0] CNT_LAST       = 11'h7FF;
  localparam logic [10:0] CNT_FIRST      = 11'h000;
  // Control bit of stream 0 channel 0 leads the frame boundary by this
  localparam logic [10:0] CTL_ADVANCE    = 11'h00A;
  localparam int unsigned CTL_SLOTS      = 8;

  // ----------------------------------------------------------------------
  // Per-stream rate codes (2 bits each)
  // ----------------------------------------------------------------------
  localparam logic [1:0] RATE_2M   = 2'h0;
  localparam logic [1:0] RATE_4M   = 2'h1;
  localparam logic [1:0] RATE_8M   = 2'h2;
  localparam logic [1:0] RATE_16M  = 2'h3;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RATE   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CMWR   = 8'h0C;

  localparam int unsigned CTRL_STANDBY_BIT = 0;
  localparam int unsigned STAT_STRAP_BIT   = 0;
  localparam int unsigned STAT_BUSY_BIT    = 1;
  localparam int unsigned STAT_ODE_BIT     = 2;
  localparam int unsigned CMWR_CHAN_LSB    = 0;
  localparam int unsigned CMWR_STREAM_LSB  = 8;
  localparam int unsigned CMWR_ENABLE_BIT  = 16;

  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] RATE_RESET  = 32'hFFFF_FFFF;
  localparam logic [31:0] CMWR_RESET  = 32'h0000_0000;
  localparam logic [31:0] CMWR_MASK   = 32'h0001_0FFF;
  localparam logic        STRAP_RESET = 1'b1;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
  } wb_req_t;

  typedef struct packed {
    logic        isRate;
    logic [31:0] data;
  } link_msg_t;

endpackage : chan_ctl_pkg

// [verilog/output_enable_and_channel_control.sv]
`timescale 1ns/1ps
// Functional notes
// [RL1] With the strap low the serial outputs are always driven and per-channel tri-state is left to external drivers; the code tri-states them in reset.
// [RL2] With the strap high the device tri-states each channel itself according to its memory enable bit.
// [RL3] The strap level is caught at the end of reset and fixes the output configuration.
// [RL4] The strap is an asynchronous input and is synchronised before use.
// [RL5] Enabling is resolved as reset first, then drive-enable pin, then standby bit, then channel bit.
// [RL6] If any enabling term is off, data is driven high (strap 0) or tri-stated (strap 1), control lines low; the code tri-states data in reset.
// [RL7] With every enabling term on, data and control lines are both actively driven whatever the strap.
// [RL8] Each control bit is a copy of the channel enable bit, low meaning that channel is to be tri-stated.
// [RL9] Control lines shift one bit per output clock period, independent of the stream rates.
// [RL10] Line 0 carries the even streams 0 to 14 and line 1 the odd streams 1 to 15.
// [RL11] Stream 0 channel 0 control bit goes out on line 0 ten output clock periods before the frame boundary.
// [RL12] Streams 14 and 15 channel 0 control bits go out three periods before the frame boundary.
// [RL13] Slower streams repeat the bit over the whole channel: 2, 4 or 8 times; 16 Mbps streams send it once.
// [RL14] Each stream slot on a line comes back every eight output clock periods.
// [RL15] Output clock periods are counted 1 to 2048 with the frame boundary after 2048.
// [RL16] Control lines change only on the active edge of the output clock.

module output_enable_and_channel_control #(
  parameter int unsigned NUM_STREAMS  = chan_ctl_pkg::NUM_STREAMS,
  parameter int unsigned NUM_CHANNELS = chan_ctl_pkg::NUM_CHANNELS
) (
  // System clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // Wishbone slave
  input  wire logic                   wbCyc,
  input  wire logic                   wbStb,
  input  wire logic                   wbWe,
  input  wire logic [7:0]             wbAdr,
  input  wire logic [3:0]             wbSel,
  input  wire logic [31:0]            wbDatIn,
  output      logic [31:0]            wbDatOut,
  output      logic                   wbAck,
  // Asynchronous pins
  input  wire logic                   local_output_select_strap,
  input  wire logic                   output_drive_enable_pin,
  // Link domain
  input  wire logic                   out_clk_16m,
  input  wire logic                   frameEnd,
  input  wire logic [NUM_STREAMS-1:0] streamData,
  output      logic [NUM_STREAMS-1:0] local_serial_out,
  output      logic [NUM_STREAMS-1:0] local_serial_out_en,
  output      logic [1:0]             local_chan_ctl_line
);

  // ----------------------------------------------------------------------
  // Bus state machine types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_ACK  = 3'b100
  } bus_state_t;

  // Merge write data into a register under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------------
  // System domain: strap capture
  // ----------------------------------------------------------------------
  logic strapMeta_q;
  logic strapSync_q;
  logic strapSel_q;
  logic capturePending_q;

  // Synchroniser kept out of reset so the pin level is settled at release
  always_ff @(posedge ref_clk) begin
    strapMeta_q <= local_output_select_strap;  // RL4
    strapSync_q <= strapMeta_q;
  end

  // Strap is frozen once, on the first edge after reset release
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      capturePending_q <= 1'b1;
      strapSel_q       <= chan_ctl_pkg::STRAP_RESET;
    end else if (capturePending_q) begin
      capturePending_q <= 1'b0;
      strapSel_q       <= strapSync_q;  // RL3
    end
  end

  // ----------------------------------------------------------------------
  // System domain: registers and bus
  // ----------------------------------------------------------------------
  chan_ctl_pkg::wb_req_t   req;
  chan_ctl_pkg::link_msg_t msg_q;
  bus_state_t              busState_q;
  logic [31:0]             ctrl_q;
  logic [31:0]             rate_q;
  logic [31:0]             cmwr_q;
  logic [31:0]             rdData_q;
  logic                    reqTgl_q;
  logic                    ackMeta_q;
  logic                    ackSync_q;
  logic                    ackSeen_q;
  logic                    odeStat_q;
  logic                    odeStatMeta_q;
  logic                    newReq;
  logic                    toLink;

  assign req    = '{adr: wbAdr, dat: wbDatIn, sel: wbSel, we: wbWe};
  assign newReq = wbCyc && wbStb && (busState_q == BUS_IDLE);
  // Writes to rate or memory must reach the link side before the ack
  assign toLink = req.we && (req.adr == chan_ctl_pkg::ADDR_RATE ||
                             req.adr == chan_ctl_pkg::ADDR_CMWR);
  assign wbAck    = (busState_q == BUS_ACK);
  assign wbDatOut = rdData_q;

  // Bus sequencing: one cycle for local registers, handshake for link writes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busState_q <= BUS_IDLE;
    end else begin
      case (busState_q)
        BUS_IDLE: begin
          if (newReq) begin
            busState_q <= toLink ? BUS_WAIT : BUS_ACK;
          end
        end
        BUS_WAIT: begin
          if (ackSync_q != ackSeen_q) begin
            busState_q <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          busState_q <= BUS_IDLE;
        end
        default: begin
          busState_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // Register writes take effect when the request is taken
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= chan_ctl_pkg::CTRL_RESET;
      rate_q <= chan_ctl_pkg::RATE_RESET;
      cmwr_q <= chan_ctl_pkg::CMWR_RESET;
    end else if (newReq && req.we) begin
      if (req.adr == chan_ctl_pkg::ADDR_CTRL) begin
        ctrl_q <= merge(ctrl_q, req.dat, req.sel) & 32'h0000_0001;
      end else if (req.adr == chan_ctl_pkg::ADDR_RATE) begin
        rate_q <= merge(rate_q, req.dat, req.sel);
      end else if (req.adr == chan_ctl_pkg::ADDR_CMWR) begin
        cmwr_q <= merge(cmwr_q, req.dat, req.sel) & chan_ctl_pkg::CMWR_MASK;
      end
    end
  end

  // Read data; unmapped addresses read zero and ignore writes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdData_q <= 32'h0000_0000;
    end else if (newReq && !req.we) begin
      if (req.adr == chan_ctl_pkg::ADDR_CTRL) begin
        rdData_q <= ctrl_q;
      end else if (req.adr == chan_ctl_pkg::ADDR_RATE) begin
        rdData_q <= rate_q;
      end else if (req.adr == chan_ctl_pkg::ADDR_STATUS) begin
        rdData_q <= 32'h0000_0000;
        rdData_q[chan_ctl_pkg::STAT_STRAP_BIT] <= strapSel_q;
        rdData_q[chan_ctl_pkg::STAT_BUSY_BIT]  <= (reqTgl_q != ackSync_q);
        rdData_q[chan_ctl_pkg::STAT_ODE_BIT]   <= odeStat_q;
      end else if (req.adr == chan_ctl_pkg::ADDR_CMWR) begin
        rdData_q <= cmwr_q;
      end else begin
        rdData_q <= 32'h0000_0000;
      end
    end
  end

  // Launch a toggle handshake carrying the merged word to the link side
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reqTgl_q <= 1'b0;
      msg_q    <= '0;
    end else if (newReq && toLink) begin
      reqTgl_q     <= ~reqTgl_q;
      msg_q.isRate <= (req.adr == chan_ctl_pkg::ADDR_RATE);
      msg_q.data   <= (req.adr == chan_ctl_pkg::ADDR_RATE) ?
                      merge(rate_q, req.dat, req.sel) :
                      merge(cmwr_q, req.dat, req.sel) & chan_ctl_pkg::CMWR_MASK;
    end
  end

  logic linkAckTgl_q;

  // Return toggle and pin status brought back into the system domain
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ackMeta_q     <= 1'b0;
      ackSync_q     <= 1'b0;
      ackSeen_q     <= 1'b0;
      odeStatMeta_q <= 1'b0;
      odeStat_q     <= 1'b0;
    end else begin
      ackMeta_q     <= linkAckTgl_q;
      ackSync_q     <= ackMeta_q;
      ackSeen_q     <= ackSync_q;
      odeStatMeta_q <= output_drive_enable_pin;
      odeStat_q     <= odeStatMeta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: reset and level synchronisers
  // ----------------------------------------------------------------------
  logic linkRstMeta_q;
  logic linkRst_q;
  logic odeMeta_q;
  logic odeSync_q;
  logic sbyMeta_q;
  logic sbySync_q;
  logic strapLinkMeta_q;
  logic strapLink_q;
  logic reqMeta_q;
  logic reqSync_q;

  // Reset asserts at once and releases on the link clock
  always_ff @(posedge out_clk_16m or posedge reset) begin
    if (reset) begin
      linkRstMeta_q <= 1'b1;
      linkRst_q     <= 1'b1;
    end else begin
      linkRstMeta_q <= 1'b0;
      linkRst_q     <= linkRstMeta_q;
    end
  end

  // Two-flop synchronisers for pin, standby, strap and request toggle
  always_ff @(posedge out_clk_16m or posedge linkRst_q) begin
    if (linkRst_q) begin
      odeMeta_q       <= 1'b0;
      odeSync_q       <= 1'b0;
      sbyMeta_q       <= 1'b0;
      sbySync_q       <= 1'b0;
      strapLinkMeta_q <= chan_ctl_pkg::STRAP_RESET;
      strapLink_q     <= chan_ctl_pkg::STRAP_RESET;
      reqMeta_q       <= 1'b0;
      reqSync_q       <= 1'b0;
    end else begin
      odeMeta_q       <= output_drive_enable_pin;
      odeSync_q       <= odeMeta_q;
      sbyMeta_q       <= ctrl_q[chan_ctl_pkg::CTRL_STANDBY_BIT];
      sbySync_q       <= sbyMeta_q;
      strapLinkMeta_q <= strapSel_q;
      strapLink_q     <= strapLinkMeta_q;
      reqMeta_q       <= reqTgl_q;
      reqSync_q       <= reqMeta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: rate table and connection memory enable bits
  // ----------------------------------------------------------------------
  logic [31:0]                         linkRate_q;
  logic [NUM_STREAMS-1:0][NUM_CHANNELS-1:0] enMem_q;
  logic                                newMsg;

  // Payload is stable since the toggle was launched, so it is read here
  assign newMsg = (reqSync_q != linkAckTgl_q);

  always_ff @(posedge out_clk_16m or posedge linkRst_q) begin
    if (linkRst_q) begin
      linkAckTgl_q <= 1'b0;
      linkRate_q   <= chan_ctl_pkg::RATE_RESET;
      enMem_q      <= '0;
    end else if (newMsg) begin
      linkAckTgl_q <= reqSync_q;
      if (msg_q.isRate) begin
        linkRate_q <= msg_q.data;
      end else begin
        enMem_q[msg_q.data[chan_ctl_pkg::CMWR_STREAM_LSB +: 4]]
               [msg_q.data[chan_ctl_pkg::CMWR_CHAN_LSB +: 8]]
          <= msg_q.data[chan_ctl_pkg::CMWR_ENABLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: period counter
  // ----------------------------------------------------------------------
  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic [10:0] ctlPos;

  // Count holds period number minus one; frameEnd marks period 2048
  assign cnt_d  = frameEnd ? chan_ctl_pkg::CNT_FIRST : cnt_q + 11'h001;  // RL15
  // Control slot position runs ten periods ahead of the data
  assign ctlPos = cnt_d + chan_ctl_pkg::CTL_ADVANCE;  // RL11

  always_ff @(posedge out_clk_16m or posedge linkRst_q) begin
    if (linkRst_q) begin
      cnt_q <= chan_ctl_pkg::CNT_LAST;
    end else begin
      cnt_q <= cnt_d;  // RL15
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: enable resolution and outputs
  // ----------------------------------------------------------------------
  logic                   globalOn;
  logic [NUM_STREAMS-1:0] dataOn;
  logic [1:0]             ctlBit;

  // Reset, then drive-enable pin, then standby, then per-channel bit
  assign globalOn = !linkRst_q && odeSync_q && sbySync_q;  // RL5

  // Per-stream data enable from the channel currently on the stream
  always_comb begin
    logic [1:0] rate;
    logic [7:0] chan;
    rate   = 2'h0;
    chan   = 8'h00;
    dataOn = '0;
    for (int s = 0; s < NUM_STREAMS; s++) begin
      rate      = linkRate_q[2*s +: 2];
      chan      = cnt_d[10:3] >> (chan_ctl_pkg::RATE_16M - rate);
      dataOn[s] = globalOn && enMem_q[s][chan];  // RL2
    end
  end

  // Control bits: slot picks the stream pair, rate picks the channel
  always_comb begin
    logic [1:0] rate;
    logic [7:0] chan;
    logic [3:0] stream;
    rate   = 2'h0;
    chan   = 8'h00;
    stream = 4'h0;
    ctlBit = 2'h0;
    for (int l = 0; l < 2; l++) begin
      stream    = {ctlPos[2:0], l[0]};  // RL10 RL14 RL12
      rate      = linkRate_q[2*stream +: 2];
      chan      = ctlPos[10:3] >> (chan_ctl_pkg::RATE_16M - rate);  // RL13
      ctlBit[l] = globalOn && enMem_q[stream][chan];  // RL8 RL6
    end
  end

  // Outputs change only on the output clock edge
  always_ff @(posedge out_clk_16m or posedge linkRst_q) begin
    if (linkRst_q) begin
      local_serial_out    <= '1;
      local_serial_out_en <= '0;
      local_chan_ctl_line <= 2'h0;
    end else begin
      local_chan_ctl_line <= ctlBit;  // RL9 RL16
      for (int s = 0; s < NUM_STREAMS; s++) begin
        // Strap low: always driven, idle high; strap high: tri-state
        local_serial_out[s]    <= dataOn[s] ? streamData[s] : 1'b1;  // RL6 RL7
        local_serial_out_en[s] <= dataOn[s] || !strapLink_q;  // RL1 RL2 RL7
      end
    end
  end

endmodule : output_enable_and_channel_control

// [verification/chan_ctl_chk.sv]
`timescale 1ns/1ps
module chan_ctl_chk #(
  parameter int unsigned NUM_STREAMS = 16
) (
  // Clocks and reset
  input wire logic                   ref_clk,
  input wire logic                   reset,
  input wire logic                   out_clk_16m,
  // Bus
  input wire logic                   wbCyc,
  input wire logic                   wbStb,
  input wire logic                   wbWe,
  input wire logic [7:0]             wbAdr,
  input wire logic [31:0]            wbDatOut,
  input wire logic                   wbAck,
  // Pins
  input wire logic                   local_output_select_strap,
  input wire logic                   output_drive_enable_pin,
  input wire logic [NUM_STREAMS-1:0] local_serial_out,
  input wire logic [NUM_STREAMS-1:0] local_serial_out_en,
  input wire logic [1:0]             local_chan_ctl_line
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic       strapQ;
  logic [3:0] linkUpQ;
  // Strap as seen during reset; the bench holds the pin steady there
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strapQ <= local_output_select_strap;
    end
  end
  // Link periods since reset, so the strap crossing has time to land
  always_ff @(posedge out_clk_16m or posedge reset) begin
    if (reset) begin
      linkUpQ <= 4'h0;
    end else if (linkUpQ != 4'hF) begin
      linkUpQ <= linkUpQ + 4'h1;
    end
  end
  // Link write needs a handshake, so its ack cannot be quick
  sequence slowAck_s;
    (!wbAck) [*4] ##[1:20] wbAck;
  endsequence
  // ----------------------------------------------------------------
  // Bus assertions
  // ----------------------------------------------------------------
  ack_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
    wbAck |=> !wbAck) else $error("ack held longer than one cycle");
  read_ack_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(wbStb) && wbCyc && !wbWe |=> wbAck) else $error("read ack late");
  write_ack_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(wbStb) && wbCyc && wbWe && (wbAdr == chan_ctl_pkg::ADDR_RATE ||
    wbAdr == chan_ctl_pkg::ADDR_CMWR) |=> slowAck_s) else $error("link write ack wrong");
  unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    wbAck && !wbWe && !(wbAdr inside {8'h00, 8'h04, 8'h08, 8'h0C}) |-> wbDatOut == 32'h0)
    else $error("unmapped read not zero");
  // ----------------------------------------------------------------
  // Pin assertions
  // ----------------------------------------------------------------
  ode_ctl_low_a: assert property (@(posedge out_clk_16m) disable iff (reset)
    (!output_drive_enable_pin) [*5] |-> local_chan_ctl_line == 2'h0)
    else $error("control line active with drive pin low");
  ode_data_high_a: assert property (@(posedge out_clk_16m) disable iff (reset)
    (!output_drive_enable_pin) [*5] |-> local_serial_out == '1 &&
    (local_serial_out_en == '0 || local_serial_out_en == '1))
    else $error("data not parked with drive pin low");
  undriven_high_a: assert property (@(posedge out_clk_16m) disable iff (reset)
    &(local_serial_out | local_serial_out_en)) else $error("released pin not high");
  strap_low_a: assert property (@(posedge out_clk_16m) disable iff (reset)
    linkUpQ == 4'hF && !strapQ |-> local_serial_out_en == '1)
    else $error("pin released with strap low");
endmodule : chan_ctl_chk

// [verification/frame_partner.sv]
`timescale 1ns/1ps
module frame_partner (
  // Link clock and reset
  input  wire logic        out_clk_16m,
  input  wire logic        reset,
  // Frame timing
  output      logic        frameEnd,
  output      logic [10:0] periodIdx,
  // Device pins and board level
  input  wire logic [15:0] serialOut,
  input  wire logic [15:0] serialOutEn,
  output      logic [15:0] pinLevel
);
  // Period index 0..2047; frameEnd marks the last period of the frame
  always_ff @(posedge out_clk_16m or posedge reset) begin
    if (reset) begin
      periodIdx <= 11'h000;
      frameEnd  <= 1'b0;
    end else begin
      periodIdx <= periodIdx + 11'h001;
      frameEnd  <= (periodIdx == 11'h7FE);
    end
  end
  // Board pull-ups: a released pin reads high, never a stale value
  assign pinLevel = (serialOut & serialOutEn) | ~serialOutEn;
endmodule : frame_partner

// [verification/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, (e), (g)); end end
module tb_top;
  logic        ref_clk = 1'b0;
  logic        out_clk_16m = 1'b0;
  logic        reset = 1'b1;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0;
  logic        local_output_select_strap = 1'b0;
  logic        output_drive_enable_pin = 1'b0;
  logic [15:0] streamData = 16'h0;
  logic [31:0] wbDatOut, rateVal, rdVal;
  logic        wbAck, frameEnd, stby, strapLvl;
  logic [15:0] local_serial_out, local_serial_out_en, pinLevel;
  logic [1:0]  local_chan_ctl_line;
  logic [10:0] periodIdx;
  bit          mem [0:15][0:255];
  int          mismatches = 0;
  int          n_checks = 0;

  // Unrelated clocks; fresh random data every link period
  always #5 ref_clk = ~ref_clk;
  always #6 out_clk_16m = ~out_clk_16m;
  always @(posedge out_clk_16m) streamData <= 16'($urandom());

  output_enable_and_channel_control u_dut (.ref_clk, .reset, .wbCyc, .wbStb, .wbWe,
    .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .wbAck, .local_output_select_strap,
    .output_drive_enable_pin, .out_clk_16m, .frameEnd, .streamData, .local_serial_out,
    .local_serial_out_en, .local_chan_ctl_line);
  frame_partner u_far (.out_clk_16m, .reset, .frameEnd, .periodIdx,
    .serialOut(local_serial_out), .serialOutEn(local_serial_out_en), .pinLevel);

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Request held until ack; the wait is bounded so a dead slave fails
  task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatIn, wbSel} <= {2'b11, w, a, d, s};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 60);
    if (n >= 60) `CHK("wbAck", 1'b1, wbAck)
    r = wbDatOut;
    {wbCyc, wbStb} <= 2'b00;
  endtask : wbXfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wbXfer(1'b1, a, d, s, rdVal);
  endtask : wr
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m);
    wbXfer(1'b0, a, 32'h0, 4'hF, rdVal);
    `CHK(nm, e, rdVal & m)
  endtask : rdChk
  task automatic setEn(input int s, input int c, input bit e);
    logic [31:0] d;
    d = {15'h0, e, 4'h0, 4'(s), 8'(c)};
    mem[s][c] = e;
    wr(chan_ctl_pkg::ADDR_CMWR, d, 4'hF);
    rdChk("cmem", chan_ctl_pkg::ADDR_CMWR, d, chan_ctl_pkg::CMWR_MASK);
  endtask : setEn

  // ----------------------------------------------------------------
  // Expectations and scenarios
  // ----------------------------------------------------------------
  function automatic logic [1:0] expCtl(int p);
    int q, s;
    logic [1:0] r;
    q = (p + 9) % 2048;
    for (int l = 0; l < 2; l++) begin
      s = 2 * (q % 8) + l;
      r[l] = output_drive_enable_pin & stby & mem[s][(q >> 3) >> (3 - rateVal[2*s +: 2])];
    end
    return r;
  endfunction : expCtl
  function automatic logic [15:0] expTerm(int p);
    logic [15:0] t;
    for (int s = 0; s < 16; s++) begin
      t[s] = output_drive_enable_pin & stby & mem[s][((p - 1) >> 3) >> (3 - rateVal[2*s +: 2])];
    end
    return t;
  endfunction : expTerm
  task automatic doReset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk); // Link side asserts its own reset at once
    reset <= 1'b0;
    strapLvl = local_output_select_strap;
    stby = 1'b0;
    rateVal = chan_ctl_pkg::RATE_RESET;
    foreach (mem[s, c]) mem[s][c] = 1'b0;
  endtask : doReset
  // Random rates, with the two example streams pinned to known rates
  task automatic configure();
    rateVal = $urandom();
    rateVal[5:4] = chan_ctl_pkg::RATE_2M;
    rateVal[9:8] = chan_ctl_pkg::RATE_8M;
    wr(chan_ctl_pkg::ADDR_RATE, rateVal, 4'hF);
    rdChk("rate", chan_ctl_pkg::ADDR_RATE, rateVal, 32'hFFFF_FFFF);
    setEn(0, 0, 1'b1);
    setEn(14, 0, 1'b1);
    setEn(15, 0, 1'b1);
    setEn(2, 0, 1'b1);
    setEn(4, 1, 1'b1);
    repeat (24) setEn($urandom_range(15), $urandom_range(255), 1'($urandom_range(1)));
    wr(chan_ctl_pkg::ADDR_CTRL, 32'h1, 4'hF);
    stby = 1'b1;
  endtask : configure
  // One full frame, every period compared just after its launching edge
  task automatic checkFrame();
    int p;
    logic [15:0] t, sd;
    // Pin and standby changes need a few link periods to cross over
    repeat (4) @(posedge out_clk_16m);
    @(posedge frameEnd);
    repeat (2048) begin
      @(posedge out_clk_16m);
      sd = streamData;
      @(negedge out_clk_16m);
      p = int'(periodIdx) + 1;
      t = expTerm(p);
      `CHK("ctl", expCtl(p), local_chan_ctl_line)
      `CHK("pin en", strapLvl ? t : 16'hFFFF, local_serial_out_en)
      `CHK("pin", (t & sd) | ~t, pinLevel)
    end
  endtask : checkFrame
  task test_done();
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    void'($urandom(32'h0CC9));
    doReset();
    rdChk("ctrl", chan_ctl_pkg::ADDR_CTRL, chan_ctl_pkg::CTRL_RESET, 32'hFFFF_FFFF);
    rdChk("rate", chan_ctl_pkg::ADDR_RATE, chan_ctl_pkg::RATE_RESET, 32'hFFFF_FFFF);
    rdChk("status", chan_ctl_pkg::ADDR_STATUS, 32'h0, 32'h5);
    wr(8'h10, 32'hFFFF_FFFF, 4'hF);
    rdChk("unmapped", 8'h10, 32'h0, 32'hFFFF_FFFF);
    wr(chan_ctl_pkg::ADDR_CTRL, 32'h1, 4'h0);
    rdChk("ctrl lanes", chan_ctl_pkg::ADDR_CTRL, 32'h0, 32'hFFFF_FFFF);
    configure();
    output_drive_enable_pin <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rdChk("ode", chan_ctl_pkg::ADDR_STATUS, 32'h4, 32'h4);
    checkFrame();
    local_output_select_strap <= 1'b1;
    rdChk("strap kept", chan_ctl_pkg::ADDR_STATUS, 32'h0, 32'h1);
    output_drive_enable_pin <= 1'b0;
    repeat (40) @(posedge ref_clk);
    output_drive_enable_pin <= 1'b1;
    wr(chan_ctl_pkg::ADDR_CTRL, 32'h0, 4'hF);
    stby = 1'b0;
    checkFrame();
    doReset();
    rdChk("strap high", chan_ctl_pkg::ADDR_STATUS, 32'h1, 32'h1);
    configure();
    checkFrame();
    test_done();
  end
  // Watchdog: about four times the expected run
  initial begin
    #600000;
    mismatches++;
    test_done();
  end
endmodule : tb_top

bind output_enable_and_channel_control chan_ctl_chk #(.NUM_STREAMS(NUM_STREAMS)) u_chk (
  .ref_clk, .reset, .out_clk_16m, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbDatOut, .wbAck,
  .local_output_select_strap, .output_drive_enable_pin, .local_serial_out,
  .local_serial_out_en, .local_chan_ctl_line);
